// ==== shared/usart_rx_pkg.sv ====
// Overview of operation
// - slave receive acts as master except in sleep; single-receive ignored.
// - with continuous receive set, a word is received during sleep.
// - a completed word moves from the shift register to receive data.
// - receive interrupt while asleep, with its enable set, wakes the core.
// - with global enable also set, the core branches to its vector.
// - nine-bit select gives 9-bit words, otherwise 8-bit words.
// - reception starts only once continuous receive enable is set.
// - a finished word sets the complete flag; interrupt if its enable set.
// - receive status shows ninth bit and overrun flag; framing bit reads as zero.
// - receive data shows the low eight bits of each word.
// - clearing continuous receive enable clears the overrun flag.
// - unimplemented serial port register bits read as zero.
// - high-speed rate is clock over sixteen times divisor plus one.
// - baud divisor is eight bits and resets to zero.
package usart_rx_pkg;
   localparam int         ADDR_W      = 10;
   localparam logic [7:0] IDX_GLOBAL  = 8'h0B;
   localparam logic [7:0] IDX_FLAGS   = 8'h0C;
   localparam logic [7:0] IDX_RSTAT   = 8'h18;
   localparam logic [7:0] IDX_TXDATA  = 8'h19;
   localparam logic [7:0] IDX_RXDATA  = 8'h1A;
   localparam logic [7:0] IDX_ENABLES = 8'h8C;
   localparam logic [7:0] IDX_TSTAT   = 8'h98;
   localparam logic [7:0] IDX_BAUD    = 8'h99;
   localparam logic [7:0] RST_ZERO    = 8'h00;
   localparam logic [7:0] RST_TSTAT   = 8'h02;
   localparam logic [7:0] MASK_IRQ    = 8'hF7;
   localparam logic [7:0] MASK_TSTAT  = 8'hF5;
   localparam int         B_RECEIVE_COMPLETE_FLAG      = 5;
   localparam int         G_GIE       = 7;
   localparam int         RS_SERIAL_PORT_ENABLE     = 7;
   localparam int         RS_RX9      = 6;
   localparam int         RS_SINGLE_RECEIVE_ENABLE     = 5;
   localparam int         RS_CONTINUOUS_RECEIVE_ENABLE     = 4;
   localparam int         RS_ADDRESS_DETECT_ENABLE     = 3;
   localparam int         TS_CLOCK_SOURCE_SELECT     = 7;
   localparam int         TS_SYNC     = 4;
   localparam int         TS_HIGH_SPEED_BAUD_SELECT     = 2;
   localparam int         TS_TRANSMIT_SHIFTER_EMPTY     = 1;
   localparam logic [6:0] HS_RATIO    = 7'h10;
   localparam logic [6:0] LS_RATIO    = 7'h40;
   localparam logic [3:0] LAST_BIT8   = 4'h7;
   localparam logic [3:0] LAST_BIT9   = 4'h8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int         PIN_DATA    = 0;
   localparam int         PIN_CLK     = 1;
   typedef enum logic [2:0] {
      RX_OFF   = 3'h1,
      RX_SHIFT = 3'h2,
      RX_STALL = 3'h4
   } rxState_t;
endpackage : usart_rx_pkg

// ==== shared/baud_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface baud_if;
   logic [7:0] divisor;
   logic       highSpeed;
   logic       enable;
   logic       tick;
   modport gen  (input divisor, input highSpeed, input enable, output tick);
   modport user (output divisor, output highSpeed, output enable,
                 input tick);
endinterface : baud_if
`default_nettype wire

// ==== hw/baud_gen.sv ====
`timescale 1ns/1ns
`default_nettype none
module baud_gen
   import usart_rx_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // rate settings and bit tick
   baud_if.gen      rate
);
   logic [7:0] prescale;
   logic [6:0] phase;
   logic [6:0] ratio;

   assign ratio = rate.highSpeed ? HS_RATIO : LS_RATIO;

   // one tick every ratio * (divisor + 1) clocks
   always_ff @(posedge mclk) begin
      if (rst || !rate.enable) begin
         prescale  <= '0;
         phase     <= '0;
         rate.tick <= 1'b0;
      end else begin
         rate.tick <= 1'b0;
         if (prescale >= rate.divisor) begin
            prescale <= '0;
            if (phase == ratio - 7'h1) begin
               phase     <= '0;
               rate.tick <= 1'b1;
            end else begin
               phase <= phase + 7'h1;
            end
         end else begin
            prescale <= prescale + 8'h1;
         end
      end
   end
endmodule : baud_gen
`default_nettype wire

// ==== hw/usart_sync_rx.sv ====
`timescale 1ns/1ns
`default_nettype none
module usart_sync_rx
   import usart_rx_pkg::*;
(
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst,
   // register bus, write side
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output var  logic              awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output var  logic              wready,
   output var  logic [1:0]        bresp,
   output var  logic              bvalid,
   input  wire logic              bready,
   // register bus, read side
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output var  logic              arready,
   output var  logic [31:0]       rdata,
   output var  logic [1:0]        rresp,
   output var  logic              rvalid,
   input  wire logic              rready,
   // serial pins
   input  wire logic              dataPinIn,
   output var  logic              dataPinOut,
   output var  logic              dataPinOe,
   input  wire logic              clockPinIn,
   output var  logic              clockPinOut,
   output var  logic              clockPinOe,
   // core side
   input  wire logic              sleeping,
   output var  logic              irq,
   output var  logic              wakeUp,
   output var  logic              vectorBranch,
   output var  logic              bitRateTick
);
   rxState_t          state;
   rxState_t          next_state;
   logic [ADDR_W-1:0] awAddrReg;
   logic [31:0]       wDataReg;
   logic [3:0]        wStrbReg;
   logic              doWrite;
   logic [7:0]        readValue;
   logic [7:0]        enables;
   logic              flagRcif;
   logic [7:3]        rstatCtrl;
   logic              overrun;
   logic              ninth;
   logic [7:0]        tstat;
   logic [7:0]        txData;
   logic [7:0]        rxData;
   logic [7:0]        baudDivisor;
   logic              global_irq_enable;
   logic [1:0][2:0]   pinSync;
   logic [1:0]        pinLevel;
   logic [1:0]        pinRaw;
   logic              clkFall;
   logic              rxGo;
   logic [8:0]        shiftReg;
   logic [8:0]        next_shift;
   logic [3:0]        bitCount;
   logic [3:0]        lastBit;
   logic              wordDone;
   logic              overrunHit;
   logic              clearRcif;
   logic [7:0]        doneData;
   logic              doneNinth;
   logic              irqCond;

   baud_if rate ();

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [7:0]        idx);
      return a[ADDR_W-1:2] == idx;
   endfunction : hit

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return hit(a, IDX_GLOBAL) || hit(a, IDX_FLAGS) ||
             hit(a, IDX_RSTAT) || hit(a, IDX_TXDATA) ||
             hit(a, IDX_RXDATA) || hit(a, IDX_ENABLES) ||
             hit(a, IDX_TSTAT) || hit(a, IDX_BAUD);
   endfunction : mapped

   function automatic logic wrHit(input logic [7:0] idx,
                                  input logic       go,
                                  input logic [ADDR_W-1:0] a,
                                  input logic       lane);
      return go && lane && hit(a, idx);
   endfunction : wrHit

   // write channel: address and data taken in either order, answer after both
   always_ff @(posedge mclk) begin
      if (rst) begin
         awready <= 1'b1;
         wready  <= 1'b1;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            wready <= 1'b0;
         end
         if (doWrite) begin
            bvalid <= 1'b1;
            bresp  <= mapped(awAddrReg) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         awAddrReg <= '0;
         wDataReg  <= '0;
         wStrbReg  <= '0;
      end else begin
         if (awvalid && awready) begin
            awAddrReg <= awaddr;
         end
         if (wvalid && wready) begin
            wDataReg <= wdata;
            wStrbReg <= wstrb;
         end
      end
   end

   assign doWrite = !awready && !wready && !bvalid;

   // read channel: one cycle from address to data
   always_ff @(posedge mclk) begin
      if (rst) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= {24'h00_0000, readValue};
         rresp   <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // reserved and unimplemented bits come back as zero
   always_comb begin
      readValue = RST_ZERO;
      case (araddr[ADDR_W-1:2])
         IDX_GLOBAL:  readValue = {global_irq_enable, 7'h00};
         IDX_FLAGS:   readValue = {2'h0, flagRcif, 5'h00};
         IDX_RSTAT:   readValue = {rstatCtrl, 1'b0, overrun, ninth};
         IDX_TXDATA:  readValue = txData;
         IDX_RXDATA:  readValue = rxData;
         IDX_ENABLES: readValue = enables & MASK_IRQ;
         IDX_TSTAT:   readValue = (tstat & MASK_TSTAT) | RST_TSTAT;
         IDX_BAUD:    readValue = baudDivisor;
         default:     readValue = RST_ZERO;
      endcase
   end

   // software-written control registers, low byte lane only
   always_ff @(posedge mclk) begin
      if (rst) begin
         global_irq_enable         <= 1'b0;
         enables     <= RST_ZERO;
         rstatCtrl   <= '0;
         txData      <= RST_ZERO;
         tstat       <= RST_ZERO;
         baudDivisor <= RST_ZERO;
      end else begin
         if (wrHit(IDX_GLOBAL, doWrite, awAddrReg, wStrbReg[0])) begin
            global_irq_enable <= wDataReg[G_GIE];
         end
         if (wrHit(IDX_ENABLES, doWrite, awAddrReg, wStrbReg[0])) begin
            enables <= wDataReg[7:0] & MASK_IRQ;
         end
         if (wrHit(IDX_RSTAT, doWrite, awAddrReg, wStrbReg[0])) begin
            rstatCtrl <= wDataReg[7:3];
         end
         if (wrHit(IDX_TXDATA, doWrite, awAddrReg, wStrbReg[0])) begin
            txData <= wDataReg[7:0];
         end
         if (wrHit(IDX_TSTAT, doWrite, awAddrReg, wStrbReg[0])) begin
            tstat <= wDataReg[7:0] & MASK_TSTAT;
         end
         if (wrHit(IDX_BAUD, doWrite, awAddrReg, wStrbReg[0])) begin
            baudDivisor <= wDataReg[7:0];
         end
      end
   end

   assign clearRcif = wrHit(IDX_FLAGS, doWrite, awAddrReg, wStrbReg[0]) &&
                      wDataReg[B_RECEIVE_COMPLETE_FLAG];

   // divider serves the asynchronous side only
   assign rate.divisor   = baudDivisor;
   assign rate.highSpeed = tstat[TS_HIGH_SPEED_BAUD_SELECT];
   assign rate.enable    = rstatCtrl[RS_SERIAL_PORT_ENABLE] && !tstat[TS_SYNC];

   baud_gen u_baud (
      .mclk (mclk),
      .rst  (rst),
      .rate (rate)
   );

   always_ff @(posedge mclk) begin
      if (rst) begin
         bitRateTick <= 1'b0;
      end else begin
         bitRateTick <= rate.tick;
      end
   end

   // receive-only slave: pins stay inputs, nothing is driven
   always_ff @(posedge mclk) begin
      dataPinOut  <= 1'b0;
      dataPinOe   <= 1'b0;
      clockPinOut <= 1'b0;
      clockPinOe  <= 1'b0;
   end

   // pins cross in through three stages; a change needs stages 2 and 3 equal
   assign pinRaw = {clockPinIn, dataPinIn};

   always_ff @(posedge mclk) begin
      if (rst) begin
         pinSync  <= '0;
         pinLevel <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            pinSync[i] <= {pinSync[i][1:0], pinRaw[i]};
            if (pinSync[i][1] == pinSync[i][2]) begin
               pinLevel[i] <= pinSync[i][2];
            end
         end
      end
   end

   // sample data on the master's falling clock edge
   assign clkFall = pinLevel[PIN_CLK] && !pinSync[PIN_CLK][2] &&
                    !pinSync[PIN_CLK][1];

   // single-receive enable takes no part; sleep does not stop this path
   assign rxGo = rstatCtrl[RS_SERIAL_PORT_ENABLE] && tstat[TS_SYNC] &&
                 !tstat[TS_CLOCK_SOURCE_SELECT] && rstatCtrl[RS_CONTINUOUS_RECEIVE_ENABLE];

   assign lastBit    = rstatCtrl[RS_RX9] ? LAST_BIT9 : LAST_BIT8;
   assign next_shift = {pinSync[PIN_DATA][2], shiftReg[8:1]};
   assign wordDone   = (state == RX_SHIFT) && rxGo && clkFall &&
                       (bitCount == lastBit);
   // a cleared flag in the same cycle counts as the old word taken
   assign overrunHit = flagRcif && !clearRcif;
   assign doneData   = rstatCtrl[RS_RX9] ? next_shift[7:0]
                                         : next_shift[8:1];
   assign doneNinth  = rstatCtrl[RS_RX9] && next_shift[8];

   always_comb begin
      next_state = state;
      case (state)
         RX_OFF: begin
            if (rxGo) begin
               next_state = RX_SHIFT;
            end
         end
         RX_SHIFT: begin
            if (!rxGo) begin
               next_state = RX_OFF;
            end else if (wordDone && overrunHit) begin
               next_state = RX_STALL;
            end
         end
         RX_STALL: begin
            if (!rstatCtrl[RS_CONTINUOUS_RECEIVE_ENABLE]) begin
               next_state = RX_OFF;
            end
         end
         default: next_state = RX_OFF;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= RX_OFF;
      end else begin
         state <= next_state;
      end
   end

   // shift register, least significant bit first
   always_ff @(posedge mclk) begin
      if (rst) begin
         shiftReg <= '0;
         bitCount <= '0;
      end else if (state != RX_SHIFT || !rxGo) begin
         bitCount <= '0;
      end else if (clkFall) begin
         shiftReg <= next_shift;
         bitCount <= wordDone ? 4'h0 : bitCount + 4'h1;
      end
   end

   // on overrun the older word is kept and the new one dropped
   always_ff @(posedge mclk) begin
      if (rst) begin
         rxData <= RST_ZERO;
         ninth  <= 1'b0;
      end else if (wordDone && !overrunHit) begin
         rxData <= doneData;
         ninth  <= doneNinth;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         overrun <= 1'b0;
      end else if (!rstatCtrl[RS_CONTINUOUS_RECEIVE_ENABLE]) begin
         overrun <= 1'b0;
      end else if (wordDone && overrunHit) begin
         overrun <= 1'b1;
      end
   end

   // setting wins over a write-one clear in the same cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         flagRcif <= 1'b0;
      end else if (wordDone && !overrunHit) begin
         flagRcif <= 1'b1;
      end else if (clearRcif) begin
         flagRcif <= 1'b0;
      end
   end

   assign irqCond = flagRcif && enables[B_RECEIVE_COMPLETE_FLAG];

   always_ff @(posedge mclk) begin
      if (rst) begin
         irq          <= 1'b0;
         wakeUp       <= 1'b0;
         vectorBranch <= 1'b0;
      end else begin
         irq          <= irqCond;
         wakeUp       <= irqCond && sleeping;
         vectorBranch <= irqCond && global_irq_enable;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence sWordIn;
      wordDone && !overrunHit;
   endsequence

   sequence sWordLost;
      wordDone && overrunHit;
   endsequence

   property pLoad;
      logic [7:0] d;
      (sWordIn, d = doneData) |=> rxData == d;
   endproperty

   chk_word_loaded: assert property (pLoad)
      else $error("received word not moved to receive data");
   chk_flag_set: assert property (sWordIn |=> flagRcif)
      else $error("complete flag not set after word");
   chk_irq_level: assert property (irqCond |=> irq)
      else $error("interrupt missing for pending flag");
   chk_wake_sleep: assert property (
      irqCond && sleeping |=> wakeUp && irq)
      else $error("no wake-up on receive interrupt in sleep");
   chk_vector_branch: assert property (
      irqCond && global_irq_enable |=> vectorBranch)
      else $error("no vector branch with global enable");
   chk_start_gate: assert property (
      !rstatCtrl[RS_CONTINUOUS_RECEIVE_ENABLE] |=>
      state == RX_OFF && !wordDone && bitCount == 4'h0)
      else $error("reception running without continuous enable");
   chk_word_length: assert property (
      wordDone |-> bitCount == (rstatCtrl[RS_RX9] ? LAST_BIT9 : LAST_BIT8))
      else $error("word length does not match nine-bit select");
   chk_ninth_bit: assert property (
      sWordIn and !rstatCtrl[RS_RX9] |=> !ninth)
      else $error("ninth bit set in eight-bit mode");
   chk_overrun_set: assert property (
      sWordLost |=> overrun ##1 (overrun || !rstatCtrl[RS_CONTINUOUS_RECEIVE_ENABLE]))
      else $error("overrun not flagged or lost too early");
   chk_overrun_clear: assert property (
      !rstatCtrl[RS_CONTINUOUS_RECEIVE_ENABLE] |=> !overrun)
      else $error("overrun kept with continuous enable clear");
   chk_unused_zero: assert property (
      $rose(rvalid) |-> rdata[31:8] == 24'h00_0000 &&
      (!rdata[2] || $past(araddr[ADDR_W-1:2]) != IDX_RSTAT))
      else $error("unimplemented bits read as one");
   chk_divisor_reset: assert property (
      @(posedge mclk) disable iff (1'b0) rst |=> baudDivisor == RST_ZERO)
      else $error("baud divisor not zero after reset");
endmodule : usart_sync_rx
`default_nettype wire

// ==== sim/sync_master.sv ====
`timescale 1ns/1ns
`default_nettype none
module sync_master (
   // serial lines toward the block
   output var logic clk,
   output var logic dat
);
   // only this side drives both lines; the block keeps them inputs
   initial begin
      clk = 1'b0;
      dat = 1'b0;
   end
   // clock stands low between frames; 125 ns per bit, lsb first
   task automatic send(input logic [8:0] w, input logic nine);
      int i;
      for (i = 0; i < (nine ? 9 : 8); i++) begin
         #32 dat = w[i];
         #31 clk = 1'b1;
         #62 clk = 1'b0;
      end
      // a released line shows the inverse so a stale bit cannot pass
      #30 dat = ~dat;
   endtask : send
endmodule : sync_master
`default_nettype wire

// ==== sim/usart_sync_slave_receiver_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module usart_sync_slave_receiver_bench;
   import usart_rx_pkg::*;
   logic              mclk = 1'b0;
   logic              rst = 1'b1;
   logic [ADDR_W-1:0] awaddr = '0;
   logic              awvalid = 1'b0;
   logic              awready;
   logic [31:0]       wdata = '0;
   logic              wvalid = 1'b0;
   logic              wready;
   logic [1:0]        bresp;
   logic              bvalid;
   logic              bready = 1'b0;
   logic [ADDR_W-1:0] araddr = '0;
   logic              arvalid = 1'b0;
   logic              arready;
   logic [31:0]       rdata;
   logic [1:0]        rresp;
   logic              rvalid;
   logic              rready = 1'b0;
   logic              linkClk;
   logic              linkDat;
   logic              dataPinOut;
   logic              dataPinOe;
   logic              clockPinOut;
   logic              clockPinOe;
   logic              sleeping = 1'b0;
   logic              irq;
   logic              wakeUp;
   logic              vectorBranch;
   logic              bitRateTick;
   int                failCount = 0;
   int                nCompared = 0;
   int                cycles = 0;
   int                tickCount = 0;
   int                tickMark = 0;

   always #5 mclk = ~mclk;

   // counts every bit tick, so a tick between two samples is not missed
   always @(negedge mclk) begin
      if (bitRateTick === 1'b1)
         tickCount++;
   end

   sync_master link (.clk(linkClk), .dat(linkDat));

   usart_sync_rx DUT (
      .mclk(mclk), .rst(rst),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .dataPinIn(linkDat), .dataPinOut(dataPinOut),
      .dataPinOe(dataPinOe), .clockPinIn(linkClk),
      .clockPinOut(clockPinOut), .clockPinOe(clockPinOe),
      .sleeping(sleeping), .irq(irq), .wakeUp(wakeUp),
      .vectorBranch(vectorBranch), .bitRateTick(bitRateTick)
   );

   task automatic giveVerdict();
      $display("compared %0d, mismatches %0d", nCompared, failCount);
      if (failCount == 0 && nCompared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : giveVerdict

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      nCompared++;
      if (got !== exp) begin
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
         failCount++;
      end
   endtask : check

   // samples at the falling edge, so the handshake edge that follows
   // is known without racing the design's own updates
   task automatic wr(input logic [7:0] idx, input logic [7:0] val,
                     input logic [1:0] er);
      int         n;
      logic       a;
      logic       d;
      logic       b;
      logic [1:0] r;
      @(posedge mclk);
      awaddr  <= {idx, 2'b00};
      wdata   <= {24'h00_0000, val};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      b = 1'b0;
      r = 2'h0;
      for (n = 0; n < 50 && !b; n++) begin
         @(negedge mclk);
         a = awvalid & awready;
         d = wvalid & wready;
         b = bvalid;
         r = bresp;
         @(posedge mclk);
         if (a) awvalid <= 1'b0;
         if (d) wvalid <= 1'b0;
         if (b) bready <= 1'b0;
      end
      check({29'h0000_0000, b, r}, {29'h0000_0000, 1'b1, er});
   endtask : wr

   task automatic rd(input logic [7:0] idx, input logic [1:0] er,
                     input logic [7:0] m, input logic [7:0] e);
      int          n;
      logic        a;
      logic        b;
      logic [31:0] v;
      logic [1:0]  r;
      @(posedge mclk);
      araddr  <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      b = 1'b0;
      v = '0;
      r = 2'h0;
      for (n = 0; n < 50 && !b; n++) begin
         @(negedge mclk);
         a = arvalid & arready;
         b = rvalid;
         v = rdata;
         r = rresp;
         @(posedge mclk);
         if (a) arvalid <= 1'b0;
         if (b) rready <= 1'b0;
      end
      check({29'h0000_0000, b, r}, {29'h0000_0000, 1'b1, er});
      check(v & {24'hFF_FFFF, m}, {24'h00_0000, e});
   endtask : rd

   task automatic waitIrq();
      int n;
      for (n = 0; n < 40 && irq !== 1'b1; n++)
         @(negedge mclk);
      check({31'h0000_0000, irq}, 32'h0000_0001);
   endtask : waitIrq

   // interval between bit ticks; the first two ticks after a change
   // are skipped since the divider may still hold its old count
   task automatic rate(input logic [7:0] div, input logic fast,
                       input int exp);
      int n;
      int c;
      wr(IDX_TSTAT, {5'h00, fast, 2'h0}, RESP_OKAY);
      wr(IDX_BAUD, div, RESP_OKAY);
      repeat (2) begin
         for (n = 0; n < 2000 && bitRateTick !== 1'b1; n++)
            @(negedge mclk);
         @(negedge mclk);
      end
      for (c = 1; c < 2000 && bitRateTick !== 1'b1; c++)
         @(negedge mclk);
      check(c, exp);
   endtask : rate

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failCount++;
         giveVerdict();
      end
   end

   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      rd(IDX_FLAGS, RESP_OKAY, 8'hFF, 8'h00);
      rd(IDX_RSTAT, RESP_OKAY, 8'hFF, 8'h00);
      rd(IDX_TXDATA, RESP_OKAY, 8'hFF, 8'h00);
      rd(IDX_RXDATA, RESP_OKAY, 8'hFF, 8'h00);
      rd(IDX_ENABLES, RESP_OKAY, 8'hFF, 8'h00);
      rd(IDX_TSTAT, RESP_OKAY, 8'hFF, 8'h02);
      rd(IDX_BAUD, RESP_OKAY, 8'hFF, 8'h00);
      rd(8'h40, RESP_SLVERR, 8'hFF, 8'h00);
      wr(8'h40, 8'h55, RESP_SLVERR);
      wr(IDX_ENABLES, 8'hFF, RESP_OKAY);
      rd(IDX_ENABLES, RESP_OKAY, 8'hFF, 8'hF7);
      wr(IDX_TXDATA, 8'hC3, RESP_OKAY);
      rd(IDX_TXDATA, RESP_OKAY, 8'hFF, 8'hC3);
      wr(IDX_RSTAT, 8'h80, RESP_OKAY);
      rate(8'h00, 1'b1, 16);
      rate(8'h03, 1'b1, 64);
      rate(8'h00, 1'b0, 64);
      rate(8'h19, 1'b1, 416);
      rd(IDX_BAUD, RESP_OKAY, 8'hFF, 8'h19);
      wr(IDX_TSTAT, 8'h10, RESP_OKAY);
      rd(IDX_TSTAT, RESP_OKAY, 8'hFF, 8'h12);
      tickMark = tickCount;
      wr(IDX_RSTAT, 8'hA0, RESP_OKAY);
      link.send(9'h05A, 1'b0);
      repeat (20) @(negedge mclk);
      rd(IDX_FLAGS, RESP_OKAY, 8'hFF, 8'h00);
      wr(IDX_ENABLES, 8'h20, RESP_OKAY);
      wr(IDX_GLOBAL, 8'hFF, RESP_OKAY);
      rd(IDX_GLOBAL, RESP_OKAY, 8'hFF, 8'h80);
      wr(IDX_RSTAT, 8'hB0, RESP_OKAY);
      @(posedge mclk) sleeping <= 1'b1;
      link.send(9'h0A5, 1'b0);
      waitIrq();
      repeat (2) @(negedge mclk);
      check({31'h0000_0000, wakeUp}, 32'h0000_0001);
      check({31'h0000_0000, vectorBranch}, 32'h0000_0001);
      rd(IDX_FLAGS, RESP_OKAY, 8'hFF, 8'h20);
      rd(IDX_RSTAT, RESP_OKAY, 8'hFF, 8'hB0);
      rd(IDX_RXDATA, RESP_OKAY, 8'hFF, 8'hA5);
      wr(IDX_FLAGS, 8'h20, RESP_OKAY);
      rd(IDX_FLAGS, RESP_OKAY, 8'hFF, 8'h00);
      @(negedge mclk);
      check({31'h0000_0000, irq}, 32'h0000_0000);
      @(posedge mclk) sleeping <= 1'b0;
      wr(IDX_RSTAT, 8'hF0, RESP_OKAY);
      link.send(9'h13C, 1'b1);
      waitIrq();
      check({31'h0000_0000, wakeUp}, 32'h0000_0000);
      rd(IDX_RSTAT, RESP_OKAY, 8'hFF, 8'hF1);
      rd(IDX_RXDATA, RESP_OKAY, 8'hFF, 8'h3C);
      // flag left set, so this word must be dropped as an overrun
      link.send(9'h0F0, 1'b1);
      repeat (20) @(negedge mclk);
      rd(IDX_RSTAT, RESP_OKAY, 8'hFF, 8'hF3);
      rd(IDX_RXDATA, RESP_OKAY, 8'hFF, 8'h3C);
      wr(IDX_RSTAT, 8'hE0, RESP_OKAY);
      rd(IDX_RSTAT, RESP_OKAY, 8'hFE, 8'hE0);
      @(negedge mclk);
      check(tickCount, tickMark);
      check({28'h000_0000, dataPinOe, dataPinOut, clockPinOe,
             clockPinOut}, 32'h0000_0000);
      giveVerdict();
   end
endmodule : usart_sync_slave_receiver_bench
`default_nettype wire
